//--- bench/host_model.sv
// Purpose: Host or modem on the far side of the serial connector
// Assumes: Frame settings are changed only while the line is idle
// Notes: Receiver records {parity, stop, data} of each frame sent by the port
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input wire logic pclk,
  input wire logic txd,
  input wire logic dtr,
  input wire logic rts,
  input wire logic online,
  input wire logic ready,
  output logic rxd,
  output logic dsr,
  output logic cts
);
  int bit_cyc = 10;
  int nbits = 8;
  bit par_on = 1'b0;
  bit par_odd = 1'b0;
  int gate = 0;
  logic [9:0] got_q[$];

  assign dsr = online;
  assign cts = ready;
  initial rxd = 1'b1;

  task automatic tx_bit(input logic b);
    rxd <= b;
    repeat (bit_cyc) @(posedge pclk);
  endtask

  // Waits at a character boundary while the port signals a nearly full receive buffer
  task automatic send(input logic [7:0] c);
    int i;
    while ((gate == 1 && dtr !== 1'b1) || (gate == 2 && rts !== 1'b1)) @(posedge pclk);
    tx_bit(1'b0);
    for (i = 0; i < nbits; i++) tx_bit(c[i]);
    if (par_on) tx_bit(par_odd ^ (^c[6:0]));
    tx_bit(1'b1);
  endtask

  initial begin : rx_loop
    logic [9:0] w;
    int i;
    forever begin
      @(negedge txd);
      repeat (bit_cyc / 2) @(posedge pclk);
      w = '0;
      for (i = 0; i < nbits; i++) begin
        repeat (bit_cyc) @(posedge pclk);
        w[i] = txd;
      end
      if (par_on) begin
        repeat (bit_cyc) @(posedge pclk);
        w[9] = txd;
      end
      repeat (bit_cyc) @(posedge pclk);
      w[8] = txd;
      got_q.push_back(w);
    end
  end
endmodule // host_model
`default_nettype wire

//--- bench/serial_port_flow_control_test.sv
// Purpose: Self-checking bench for the serial port over APB
// Assumes: Short bit times through a low CLK_HZ value
// Notes: Host model gates its own sending on the port's flow lines
`include "uart_defs.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end
module serial_port_flow_control_test;
  localparam int CLK_HZ = 1152000;
  localparam int RATE [10] = '{300, 600, 1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic rxd, dsr, cts, txd, dtr, rts, ser_en, par_en, online, ready;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  int i, m;

  serial_port_flow_control #(.CLK_HZ(CLK_HZ)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd), .dsr(dsr), .cts(cts),
    .txd(txd), .dtr(dtr), .rts(rts), .serial_enable(ser_en), .parallel_enable(par_en));
  host_model u_host (.pclk(pclk), .txd(txd), .dtr(dtr), .rts(rts), .online(online),
    .ready(ready), .rxd(rxd), .dsr(dsr), .cts(cts));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Three runs of 100 characters into the receive buffer dominate the run time
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 80000) begin
      num_errors++;
      $display("[FAIL] timeout");
      end_sim();
    end
  end

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic set_cfg(input int b, input int p, input int f, input int s);
    apb(1'b1, `CFG_OFS, 32'((s << 9) | (f << 6) | (p << 4) | b));
    u_host.bit_cyc = (CLK_HZ + RATE[b] / 2) / RATE[b];
    u_host.nbits = (p == 0) ? 8 : 7;
    u_host.par_on = (p != 0);
    u_host.par_odd = (p == 2);
    u_host.gate = (f == 1) ? 1 : ((f == 2 || f == 3) ? 2 : 0);
  endtask

  task automatic expect_char(input logic [7:0] c);
    int n;
    logic [9:0] e;
    logic [9:0] g;
    n = 0;
    while (u_host.got_q.size() == 0 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    e[7:0] = (u_host.nbits == 8) ? c : {1'b0, c[6:0]};
    e[8] = 1'b1;
    e[9] = u_host.par_on ? (u_host.par_odd ^ (^c[6:0])) : 1'b0;
    g = (u_host.got_q.size() > 0) ? u_host.got_q.pop_front() : 'x;
    `CHK("tx frame", e, g)
  endtask

  task automatic quiet();
    repeat (300) @(posedge pclk);
    `CHK("idle line", 0, u_host.got_q.size())
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    online = 1'b0;
    ready = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK("parallel_enable", 1'b1, par_en)
    `CHK("serial_enable", 1'b0, ser_en)
    apb(1'b0, `CFG_OFS, '0);
    `CHK("cfg reset", 32'h0000_0048, rdat)
    for (i = 0; i < 10; i++) begin
      apb(1'b1, `CFG_OFS, 32'(i) | 32'h0000_0040);
      apb(1'b0, `CFG_OFS, '0);
      `CHK("baud index", 4'(i), rdat[3:0])
    end
    apb(1'b1, `CFG_OFS, 32'h0000_004F);
    apb(1'b0, `CFG_OFS, '0);
    `CHK("baud clamp", 4'h8, rdat[3:0])
    for (m = 0; m < 5; m++) begin
      apb(1'b1, `CFG_OFS, 32'(m << 6) | 32'h0000_0008);
      apb(1'b0, `CFG_OFS, '0);
      `CHK("flow code", 3'(m), rdat[8:6])
    end
    apb(1'b0, 12'h014, '0);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0000_0000, rdat)
    // Port only transmits here; the host sends nothing unflowed
    set_cfg(9, 0, 0, 1);
    `CHK("serial_enable", 1'b1, ser_en)
    `CHK("parallel_enable", 1'b0, par_en)
    apb(1'b1, `TXD_OFS, 32'h0000_00A5);
    expect_char(8'hA5);
    for (m = 1; m < 3; m++) begin
      set_cfg(8, m, 0, 1);
      apb(1'b1, `TXD_OFS, 32'h0000_00B5);
      expect_char(8'hB5);
    end
    // Host sends slow with wrong parity; sticky bit then write-one clear
    set_cfg(4, 1, 0, 1);
    u_host.par_odd = 1'b1;
    u_host.send(8'h35);
    repeat (30) @(posedge pclk);
    apb(1'b0, `STAT_OFS, '0);
    `CHK("parity sticky", 1'b1, rdat[6])
    apb(1'b1, `STAT_OFS, 32'h0000_0040);
    apb(1'b0, `RXD_OFS, '0);
    `CHK("rx parity char", 9'h135, rdat[8:0])
    apb(1'b0, `STAT_OFS, '0);
    `CHK("parity cleared", 1'b0, rdat[6])
    for (m = 1; m < 4; m++) begin
      set_cfg(9, 0, m, 1);
      online <= 1'b0;
      ready <= 1'b0;
      for (i = 0; i < 4; i++) apb(1'b1, `TXD_OFS, 32'h0000_0030 + 32'(i));
      apb(1'b0, `STAT_OFS, '0);
      `CHK("tx full", 1'b1, rdat[0])
      quiet();
      online <= 1'b1;
      ready <= 1'b1;
      for (i = 0; i < 4; i++) expect_char(8'h30 + 8'(i));
      if (m == 2) begin
        `CHK("modem dtr", 1'b1, dtr)
      end
      `CHK("flow line open", 1'b1, (m == 1) ? dtr : rts)
      for (i = 0; i < 100; i++) u_host.send(8'(i));
      repeat (30) @(posedge pclk);
      `CHK("flow line held", 1'b0, (m == 1) ? dtr : rts)
      apb(1'b0, `STAT_OFS, '0);
      `CHK("rx high mark", 1'b1, rdat[3])
      apb(1'b0, `RXD_OFS, '0);
      `CHK("rx first", 9'h100, rdat[8:0])
      repeat (5) @(posedge pclk);
      `CHK("flow line freed", 1'b1, (m == 1) ? dtr : rts)
      apb(1'b1, `CTRL_OFS, 32'h0000_0001);
      apb(1'b0, `CFG_OFS, '0);
      `CHK("cfg kept", 32'(32'h0000_0209 | (m << 6)), rdat)
      apb(1'b0, `STAT_OFS, '0);
      `CHK("rx cleared", 1'b0, rdat[2])
    end
    set_cfg(9, 0, 4, 1);
    u_host.send(`XOFF_CHAR);
    repeat (30) @(posedge pclk);
    apb(1'b0, `STAT_OFS, '0);
    `CHK("xoff held", 1'b1, rdat[4])
    apb(1'b1, `TXD_OFS, 32'h0000_005A);
    quiet();
    u_host.send(`XON_CHAR);
    expect_char(8'h5A);
    apb(1'b0, `STAT_OFS, '0);
    `CHK("flow chars kept out", 1'b0, rdat[2])
    set_cfg(9, 0, 2, 0);
    `CHK("serial_enable", 1'b0, ser_en)
    `CHK("parallel_enable", 1'b1, par_en)
    `CHK("dtr parallel", 1'b0, dtr)
    end_sim();
  end
endmodule // serial_port_flow_control_test
`default_nettype wire

//--- rtl/char_fifo.sv
// Purpose: Synchronous character FIFO with fill level
// Assumes: DEPTH is a power of two
// Notes: clr empties the store without touching the data array
`timescale 1ns/100ps
`default_nettype none
module char_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clr,
  fifo_if.store f
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [LW-1:0] cnt_reg;
  logic push;
  logic pop;

  assign f.in_ready = (cnt_reg != LW'(DEPTH));
  assign f.out_valid = (cnt_reg != '0);
  assign f.out_data = mem[rd_reg];
  assign f.level = cnt_reg;
  assign push = f.in_valid && f.in_ready;
  assign pop = f.out_valid && f.out_ready;

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_reg] <= f.in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else if (clr) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wr_reg <= wr_reg + AW'(1);
      if (pop) rd_reg <= rd_reg + AW'(1);
      if (push && !pop) cnt_reg <= cnt_reg + LW'(1);
      else if (pop && !push) cnt_reg <= cnt_reg - LW'(1);
    end
  end
endmodule // char_fifo
`default_nettype wire

//--- rtl/fifo_if.sv
// Purpose: Fill and drain sides of a character FIFO
// Assumes: Single clock
// Notes: Valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
interface fifo_if #(parameter int WIDTH = 8, parameter int LW = 3);
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [WIDTH-1:0] out_data;
  logic [LW-1:0] level;
  modport store (input in_valid, in_data, out_ready,
                 output in_ready, out_valid, out_data, level);
  modport user (output in_valid, in_data, out_ready,
                input in_ready, out_valid, out_data, level);
endinterface
`default_nettype wire

//--- rtl/serial_port_flow_control.sv
// Purpose: Serial port with bit rate, parity and flow control, APB registers
// Assumes: pclk 100 MHz; modem lines are logical true-high
// Notes: Config survives the soft interface reset, only presetn restores it
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`include "uart_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module serial_port_flow_control #(
  parameter int CLK_HZ = `CLK_HZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  input wire logic dsr,
  input wire logic cts,
  output logic txd,
  output logic dtr,
  output logic rts,
  output logic serial_enable,
  output logic parallel_enable
);
  fifo_if #(.WIDTH(8), .LW(3)) txq ();
  fifo_if #(.WIDTH(8), .LW(8)) rxq ();

  logic [9:0] cfg_reg;
  logic [31:0] prdata_reg;
  logic [2:0] sticky_reg;
  logic xoff_reg;
  logic soft_rst;
  logic [1:0] rxd_sync_reg, dsr_sync_reg, cts_sync_reg;
  logic [3:0] baud_sel;
  uart_pkg::parity_e par;
  uart_pkg::flow_e flow;
  logic ser_sel;
  logic [23:0] div;
  logic [3:0] nbits;
  logic acc, wr, rd;
  logic hit;
  logic rx_high;
  logic tx_allowed;

  assign baud_sel = cfg_reg[`CFG_BAUD_LSB +: 4];
  assign par = uart_pkg::parity_e'(cfg_reg[`CFG_PAR_LSB +: 2]);
  assign flow = uart_pkg::flow_e'(cfg_reg[`CFG_FLOW_LSB +: 3]);
  assign ser_sel = cfg_reg[`CFG_SER_BIT];
  assign nbits = (par == uart_pkg::PAR_NONE) ? 4'd8 : 4'd7;

  function automatic logic [23:0] baud_div(input logic [3:0] s);
    int rate;
    rate = 57600;
    unique case (s)
      4'h0: rate = 300;
      4'h1: rate = 600;
      4'h2: rate = 1200;
      4'h3: rate = 2400;
      4'h4: rate = 4800;
      4'h5: rate = 9600;
      4'h6: rate = 19200;
      4'h7: rate = 38400;
      4'h9: rate = 115200;
      default: rate = 57600;
    endcase
    return 24'((CLK_HZ + rate / 2) / rate);
  endfunction
  assign div = baud_div(baud_sel);

  // APB decode; writes to a full transmit queue stall the bus
  assign hit = (paddr == `CFG_OFS) || (paddr == `STAT_OFS) ||
               (paddr == `TXD_OFS) || (paddr == `RXD_OFS) || (paddr == `CTRL_OFS);
  assign pready = !(psel && penable && pwrite && paddr == `TXD_OFS && !txq.in_ready);
  assign pslverr = psel && penable && !hit;
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite && hit;
  assign rd = acc && !pwrite;
  assign prdata = prdata_reg;
  assign soft_rst = wr && paddr == `CTRL_OFS && pwdata[0];
  assign txq.in_valid = psel && penable && pwrite && paddr == `TXD_OFS;
  assign txq.in_data = pwdata[7:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= `CFG_RESET;
    end else if (wr && paddr == `CFG_OFS) begin
      cfg_reg <= pwdata[9:0]; // Soft reset never reaches here
      if (pwdata[`CFG_BAUD_LSB +: 4] > `BAUD_MAX) begin
        cfg_reg[`CFG_BAUD_LSB +: 4] <= `BAUD_57600;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `CFG_OFS: prdata_reg <= {22'h0_0000, cfg_reg};
        `STAT_OFS: prdata_reg <= {23'h0_0000, sticky_reg, 1'b0, xoff_reg, rx_high,
                                  rxq.out_valid, !txq.out_valid, !txq.in_ready};
        `RXD_OFS: prdata_reg <= {23'h0_0000, rxq.out_valid, rxq.out_data};
        default: prdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // Pin inputs, two stages each
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_sync_reg <= 2'b11;
      dsr_sync_reg <= 2'b00;
      cts_sync_reg <= 2'b00;
    end else begin
      rxd_sync_reg <= {rxd_sync_reg[0], rxd};
      dsr_sync_reg <= {dsr_sync_reg[0], dsr};
      cts_sync_reg <= {cts_sync_reg[0], cts};
    end
  end

  assign serial_enable = ser_sel;
  assign parallel_enable = !ser_sel;
  assign rx_high = rxq.level >= 8'(`RX_HIGH_MARK);
  assign dtr = ser_sel && ((flow == uart_pkg::FLOW_DTR) ? !rx_high : 1'b1);
  assign rts = ser_sel && ((flow == uart_pkg::FLOW_MODEM || flow == uart_pkg::FLOW_RTS) ?
               !rx_high : 1'b1);

  always_comb begin
    tx_allowed = 1'b1;
    unique case (flow)
      uart_pkg::FLOW_DTR: tx_allowed = dsr_sync_reg[1];
      uart_pkg::FLOW_MODEM: tx_allowed = cts_sync_reg[1];
      uart_pkg::FLOW_RTS: tx_allowed = cts_sync_reg[1];
      uart_pkg::FLOW_XON: tx_allowed = !xoff_reg;
      default: tx_allowed = 1'b1;
    endcase
  end

  // Transmitter; a stopped line only holds back the next character
  uart_pkg::bit_state_e tx_state_reg;
  logic [23:0] tx_cnt_reg;
  logic [7:0] tx_sh_reg;
  logic [3:0] tx_idx_reg;
  logic tx_par_reg, txd_reg;
  logic tx_tick;
  assign tx_tick = (tx_cnt_reg == div - 24'd1);
  assign txq.out_ready = (tx_state_reg == uart_pkg::ST_IDLE) && tx_allowed && ser_sel;
  assign txd = txd_reg || !ser_sel;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state_reg <= uart_pkg::ST_IDLE;
      tx_cnt_reg <= 24'h00_0000;
      tx_sh_reg <= 8'h00;
      tx_idx_reg <= 4'h0;
      tx_par_reg <= 1'b0;
      txd_reg <= 1'b1;
    end else if (soft_rst) begin
      tx_state_reg <= uart_pkg::ST_IDLE;
      txd_reg <= 1'b1;
    end else begin
      tx_cnt_reg <= tx_tick ? 24'h00_0000 : tx_cnt_reg + 24'd1;
      unique case (tx_state_reg)
        uart_pkg::ST_IDLE: begin
          txd_reg <= 1'b1;
          tx_cnt_reg <= 24'h00_0000;
          if (txq.out_valid && txq.out_ready) begin
            tx_sh_reg <= txq.out_data;
            tx_par_reg <= (par == uart_pkg::PAR_ODD) ^ (^txq.out_data[6:0]);
            tx_idx_reg <= 4'h0;
            txd_reg <= 1'b0;
            tx_state_reg <= uart_pkg::ST_START;
          end
        end
        uart_pkg::ST_START: if (tx_tick) begin
          txd_reg <= tx_sh_reg[0];
          tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
          tx_state_reg <= uart_pkg::ST_DATA;
        end
        uart_pkg::ST_DATA: if (tx_tick) begin
          tx_idx_reg <= tx_idx_reg + 4'd1;
          if (tx_idx_reg == nbits - 4'd1) begin
            txd_reg <= (par == uart_pkg::PAR_NONE) ? 1'b1 : tx_par_reg;
            tx_state_reg <= (par == uart_pkg::PAR_NONE) ? uart_pkg::ST_STOP : uart_pkg::ST_PAR;
          end else begin
            txd_reg <= tx_sh_reg[0];
            tx_sh_reg <= {1'b0, tx_sh_reg[7:1]};
          end
        end
        uart_pkg::ST_PAR: if (tx_tick) begin
          txd_reg <= 1'b1;
          tx_state_reg <= uart_pkg::ST_STOP;
        end
        uart_pkg::ST_STOP: if (tx_tick) begin
          tx_state_reg <= uart_pkg::ST_IDLE;
        end
        default: tx_state_reg <= uart_pkg::ST_IDLE;
      endcase
    end
  end

  // Receiver samples mid-bit
  uart_pkg::bit_state_e rx_state_reg;
  logic [23:0] rx_cnt_reg;
  logic [7:0] rx_sh_reg;
  logic [3:0] rx_idx_reg;
  logic rx_done_reg, rx_perr_reg, rx_ferr_reg;
  logic rx_tick, rx_is_flow;
  assign rx_tick = (rx_cnt_reg == div - 24'd1);
  assign rx_is_flow = (flow == uart_pkg::FLOW_XON) &&
                      (rx_sh_reg == `XOFF_CHAR || rx_sh_reg == `XON_CHAR);
  assign rxq.in_valid = rx_done_reg && !rx_is_flow;
  assign rxq.in_data = rx_sh_reg;
  assign rxq.out_ready = rd && paddr == `RXD_OFS;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_reg <= uart_pkg::ST_IDLE;
      rx_cnt_reg <= 24'h00_0000;
      rx_sh_reg <= 8'h00;
      rx_idx_reg <= 4'h0;
      rx_done_reg <= 1'b0;
      rx_perr_reg <= 1'b0;
      rx_ferr_reg <= 1'b0;
    end else begin
      rx_done_reg <= 1'b0;
      rx_perr_reg <= 1'b0;
      rx_ferr_reg <= 1'b0;
      rx_cnt_reg <= rx_tick ? 24'h00_0000 : rx_cnt_reg + 24'd1;
      unique case (rx_state_reg)
        uart_pkg::ST_IDLE: begin
          rx_cnt_reg <= {1'b0, div[23:1]};
          rx_idx_reg <= 4'h0;
          if (!rxd_sync_reg[1] && ser_sel) rx_state_reg <= uart_pkg::ST_START;
        end
        uart_pkg::ST_START: if (rx_tick) begin
          rx_sh_reg <= 8'h00;
          rx_state_reg <= rxd_sync_reg[1] ? uart_pkg::ST_IDLE : uart_pkg::ST_DATA;
        end
        uart_pkg::ST_DATA: if (rx_tick) begin
          rx_sh_reg[rx_idx_reg[2:0]] <= rxd_sync_reg[1];
          rx_idx_reg <= rx_idx_reg + 4'd1;
          if (rx_idx_reg == nbits - 4'd1) begin
            rx_state_reg <= (par == uart_pkg::PAR_NONE) ? uart_pkg::ST_STOP : uart_pkg::ST_PAR;
          end
        end
        uart_pkg::ST_PAR: if (rx_tick) begin
          rx_perr_reg <= rxd_sync_reg[1] ^ (par == uart_pkg::PAR_ODD) ^ (^rx_sh_reg[6:0]);
          rx_state_reg <= uart_pkg::ST_STOP;
        end
        uart_pkg::ST_STOP: if (rx_tick) begin
          rx_ferr_reg <= !rxd_sync_reg[1];
          rx_done_reg <= 1'b1;
          rx_state_reg <= uart_pkg::ST_IDLE;
        end
        default: rx_state_reg <= uart_pkg::ST_IDLE;
      endcase
    end
  end

  // Software flow state; soft reset releases a held transmitter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xoff_reg <= 1'b0;
    end else if (soft_rst || flow != uart_pkg::FLOW_XON) begin
      xoff_reg <= 1'b0;
    end else if (rx_done_reg && rx_sh_reg == `XOFF_CHAR) begin
      xoff_reg <= 1'b1;
    end else if (rx_done_reg && rx_sh_reg == `XON_CHAR) begin
      xoff_reg <= 1'b0;
    end
  end

  // Sticky errors: parity, framing, overrun; write one clears, set wins
  logic [2:0] err_set;
  assign err_set = {rxq.in_valid && !rxq.in_ready, rx_ferr_reg, rx_perr_reg};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sticky_reg <= 3'h0;
    end else if (soft_rst) begin
      sticky_reg <= err_set;
    end else if (wr && paddr == `STAT_OFS) begin
      sticky_reg <= (sticky_reg & ~pwdata[8:6]) | err_set;
    end else begin
      sticky_reg <= sticky_reg | err_set;
    end
  end

  char_fifo #(.WIDTH(8), .DEPTH(`TX_DEPTH)) tx_fifo (
    .pclk(pclk), .presetn(presetn), .clr(soft_rst), .f(txq.store));
  char_fifo #(.WIDTH(8), .DEPTH(`RX_DEPTH)) rx_fifo (
    .pclk(pclk), .presetn(presetn), .clr(soft_rst), .f(rxq.store));

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_ONE_IFACE: assert property (serial_enable != parallel_enable)
    else $error("host interfaces not exclusive");
  AST_TXD_IDLE_PAR: assert property (!ser_sel |-> txd)
    else $error("line driven while parallel selected");
  AST_DSR_HOLD: assert property (flow == uart_pkg::FLOW_DTR && !dsr_sync_reg[1] &&
    tx_state_reg == uart_pkg::ST_IDLE |=> tx_state_reg == uart_pkg::ST_IDLE)
    else $error("sent with DSR false");
  AST_CTS_HOLD: assert property (flow == uart_pkg::FLOW_RTS && !cts_sync_reg[1] &&
    tx_state_reg == uart_pkg::ST_IDLE |=> tx_state_reg == uart_pkg::ST_IDLE)
    else $error("sent with CTS false");
  AST_DTR_HIGH: assert property (flow == uart_pkg::FLOW_DTR &&
    rxq.level >= 8'd100 |-> !dtr)
    else $error("DTR true with receive buffer near full");
  AST_DTR_MODEM: assert property (flow == uart_pkg::FLOW_MODEM && ser_sel |-> dtr)
    else $error("DTR false in modem mode");
  AST_RTS_HIGH: assert property ((flow == uart_pkg::FLOW_MODEM || flow == uart_pkg::FLOW_RTS)
    && rxq.level >= 8'd100 |-> !rts)
    else $error("RTS true with receive buffer near full");
  AST_XOFF_SET: assert property (flow == uart_pkg::FLOW_XON && rx_done_reg &&
    rx_sh_reg == 8'h13 && !soft_rst |=> xoff_reg && !txq.out_ready)
    else $error("XOFF not honoured");
  AST_START_LOW: assert property (tx_state_reg == uart_pkg::ST_START |-> !txd)
    else $error("start bit not low");
  AST_CFG_KEEP: assert property (soft_rst |=> $stable(cfg_reg))
    else $error("interface reset changed settings");
  AST_WIDTH: assert property (tx_state_reg == uart_pkg::ST_PAR |->
    par != uart_pkg::PAR_NONE && nbits == 4'd7)
    else $error("parity frame not 7 bits");
  COV_TX: cover property (tx_state_reg == uart_pkg::ST_STOP ##1
    tx_state_reg == uart_pkg::ST_IDLE);
  COV_RX: cover property (rxq.in_valid && rxq.in_ready);
  COV_XOFF: cover property ($rose(xoff_reg));
  COV_DTR_DROP: cover property ($fell(dtr) && ser_sel);
endmodule // serial_port_flow_control
`default_nettype wire

//--- rtl/uart_defs.svh
// Purpose: Offsets, field positions, reset values and counts for the serial port
// Assumes: 32-bit APB, byte addresses
// Notes: Configuration reset values are the factory settings
`ifndef UART_DEFS_SVH
`define UART_DEFS_SVH
`define CFG_OFS 12'h000
`define STAT_OFS 12'h004
`define TXD_OFS 12'h008
`define RXD_OFS 12'h00C
`define CTRL_OFS 12'h010
`define CFG_BAUD_LSB 0
`define CFG_PAR_LSB 4
`define CFG_FLOW_LSB 6
`define CFG_SER_BIT 9
`define CFG_RESET 10'h0_048
`define BAUD_57600 4'h8
`define BAUD_MAX 4'h9
`define RX_HIGH_MARK 100
`define RX_DEPTH 128
`define TX_DEPTH 4
`define XOFF_CHAR 8'h13
`define XON_CHAR 8'h11
`define CLK_HZ 100000000
`endif

//--- rtl/uart_pkg.sv
// Purpose: Types shared by the serial port modules
// Assumes: Nothing
// Notes: Codes match the configuration register fields
package uart_pkg;
  typedef enum logic [2:0] {
    FLOW_NONE = 3'b000, FLOW_DTR = 3'b001, FLOW_MODEM = 3'b010,
    FLOW_RTS = 3'b011, FLOW_XON = 3'b100
  } flow_e;
  typedef enum logic [1:0] {
    PAR_NONE = 2'b00, PAR_EVEN = 2'b01, PAR_ODD = 2'b10
  } parity_e;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_START = 3'b001, ST_DATA = 3'b010,
    ST_PAR = 3'b011, ST_STOP = 3'b100
  } bit_state_e;
endpackage
